// File: pdu_bench.sv
// Testbench for the pwm duty unit
`timescale 1ns/10ps
module pdu_bench;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [11:0] addr = 12'h000;
	logic [15:0] wdata = 16'h0000;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic sleep = 1'b0;
	logic run = 1'b0;
	logic [1:0] pre = 2'h0;
	logic [7:0] limit = 8'h03;
	logic [15:0] rdata;
	logic [7:0] count;
	logic start;
	logic [1:0] pin;
	logic [1:0] oe;
	logic [10:0] width;
	logic [1:0] pwm;
	logic [10:0] width_b;
	int errors = 0;
	int n_checks = 0;
	pdu_top pdu_top_inst (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata),
		.sleep_in(sleep), .timer_run_in(run), .timer_prescale_select_in(pre),
		.period_limit_in(limit), .period_timer_count_out(count), .period_start_out(start),
		.pwm_out(pwm), .pin_out(pin), .pin_oe_out(oe));
	pdu_load pdu_load_inst (.clk_in(clk_in), .pin_in(pin[0]), .oe_in(oe[0]),
		.start_in(start), .width_out(width));
	// Channel b feeds on-chip peripherals only
	pdu_load peri_load (.clk_in(clk_in), .pin_in(pwm[1]), .oe_in(1'b1),
		.start_in(start), .width_out(width_b));
	initial
		forever #2 clk_in = ~clk_in;
	task end_of_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_in);
		wr_s <= 1'b0;
	endtask
	task rdc(input logic [11:0] a, input logic [15:0] mask, input logic [15:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		#1;
		check("read data", rdata & mask, exp);
	endtask
	task wait_start;
		int i;
		i = 0;
		do
		begin
			@(posedge clk_in);
			#1;
			i++;
		end
		while (start !== 1'b1 && i < 2000);
		check("period start", {15'h0000, start}, 16'h0001);
	endtask
	task measure(input logic [10:0] exp);
		// One period to settle, one measured, then the result
		wait_start();
		wait_start();
		wait_start();
		@(posedge clk_in);
		#1;
		check("pulse width", {5'h00, width}, {5'h00, exp});
	endtask
	task t_setup;
		rdc(12'h394, 16'hFFFF, 16'h0003);
		rdc(12'h38E, 16'hFFFF, 16'h0000);
		rdc(12'h3A0, 16'hFFFF, 16'h0000);
		wr(12'h38E, 16'h0000);
		wr(12'h38C, 16'h0140);
		run <= 1'b1;
		wait_start();
		wr(12'h394, 16'h0012);
		wr(12'h38E, 16'h0080);
		wr(12'h390, 16'h12FF);
		rdc(12'h390, 16'hFFFF, 16'h12C0);
	endtask
	task t_periph;
		wr(12'h392, 16'h0080);
		wr(12'h390, 16'h0280);
		measure(11'h005);
		check("peripheral width", {5'h00, width_b}, 16'h000A);
		check("pin drive", {14'h0000, oe}, 16'h0001);
	endtask
	task t_prescale;
		for (int p = 0; p < 4; p++)
		begin
			@(posedge clk_in);
			pre <= p[1:0];
			measure(11'h005 << (2 * p));
		end
		@(posedge clk_in);
		pre <= 2'h0;
	endtask
	task t_buffer;
		measure(11'h005);
		wait_start();
		wr(12'h38C, 16'h0240);
		wait_start();
		@(posedge clk_in);
		#1;
		check("old duty", {5'h00, width}, 16'h0005);
		measure(11'h009);
	endtask
	task t_modes;
		wr(12'h38C, 16'hFFC0);
		measure(11'h010);
		wr(12'h38C, 16'h0140);
		wr(12'h38E, 16'h0090);
		measure(11'h00B);
		wr(12'h38E, 16'h0000);
		measure(11'h000);
		wr(12'h38E, 16'h0080);
	endtask
	task t_sleep;
		logic [7:0] held;
		wait_start();
		@(posedge clk_in);
		sleep <= 1'b1;
		@(posedge clk_in);
		#1;
		held = count;
		// A write while asleep must be ignored
		wr(12'h38C, 16'hFFC0);
		repeat (28) @(posedge clk_in);
		sleep <= 1'b0;
		#1;
		check("sleep count", {8'h00, count}, {8'h00, held});
		rdc(12'h38C, 16'hFFFF, 16'h0140);
		measure(11'h005);
	endtask
	task t_reset;
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		rdc(12'h38C, 16'hFFFF, 16'h0140);
		rdc(12'h38E, 16'hFFFF, 16'h0000);
		rdc(12'h394, 16'hFFFF, 16'h0003);
		@(posedge clk_in);
		limit <= 8'hFF;
		rdc(12'h396, 16'h3C00, 16'h2800);
		@(posedge clk_in);
		limit <= 8'h03;
		rdc(12'h396, 16'h3C00, 16'h1000);
	endtask
	initial
	begin
		#200000;
		errors++;
		end_of_test();
	end
	initial
	begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		t_setup();
		t_periph();
		t_prescale();
		t_buffer();
		t_modes();
		t_sleep();
		t_reset();
		end_of_test();
	end
endmodule

// File: pdu_load.sv
// Pin load that counts high cycles in each period
`timescale 1ns/10ps
module pdu_load
(
	// Pin and period marker
	input wire logic clk_in,
	input wire logic pin_in,
	input wire logic oe_in,
	input wire logic start_in,
	// High cycles of the last period
	output logic [10:0] width_out
);
	logic [10:0] cnt = 11'h000;
	logic lvl;
	assign lvl = oe_in ? pin_in : 1'b0; // Pull-down while undriven
	initial width_out = 11'h000;
	always @(posedge clk_in)
		if (start_in)
		begin
			width_out <= cnt;
			cnt <= {10'h000, lvl};
		end
		else
			cnt <= cnt + {10'h000, lvl};
endmodule

// File: pdu_pkg.sv
// Constants and types shared by the ten-bit pwm duty unit
// Notes on behaviour
// (RL1) Duty is high byte plus low bits 7:6
// (RL2) Duty writes any time, current cycle undisturbed
// (RL3) Timer count extended by two low bits
// (RL4) Prescale 1:1 clocks low bits every clock
// (RL5) Pulse equals duty times prescaled clock period
// (RL6) Resolution is log2 of four times period
// (RL7) Pulse above period leaves pin unchanged
// (RL8) Sleep freezes timer, state and pin level
// (RL9) Wake resumes timer from held count
// (RL10) Output frequency follows system clock
// (RL11) Reset makes pins inputs, registers reset
// (RL12) Duty fields kept across reset
// (RL13) Host selects instruction clock for timer
// (RL14) Host setup order before timer start
// (RL15) Host waits match, enables pin, writes control
// (RL16) Host may shorten setup sequence
// (RL17) Peripheral-only use keeps pin drivers off
// (RL18) Output muxed onto port latch path
// (RL19) Outputs set when timer count clears
// (RL20) Output cleared on duty match, else full
// (RL21) Duty buffers load on period match only
// (RL22) Invert bit inverts the output level
// (RL23) Disabled channel holds inactive level
package pdu_pkg;

	localparam int CHANNELS = 2;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;

	// Register offsets
	localparam logic [1:0][11:0] DUTY_OFS = {12'h390, 12'h38C};
	localparam logic [1:0][11:0] CTRL_OFS = {12'h392, 12'h38E};
	localparam logic [11:0] PIN_CTRL_OFS = 12'h394;
	localparam logic [11:0] TIMER_STAT_OFS = 12'h396;

	// Field positions
	localparam int DUTY_HIGH_LSB = 8;
	localparam int DUTY_LOW_LSB = 6;
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_INVERT_BIT = 4;
	localparam int PIN_DIR_LSB = 0;
	localparam int PIN_LATCH_LSB = 2;
	localparam int PIN_ROUTE_LSB = 4;
	localparam int STAT_SUB_LSB = 8;
	localparam int STAT_RES_LSB = 10;

	// Values after reset
	localparam logic [1:0] PIN_DIR_RESET = 2'h3;
	localparam logic [1:0] PIN_LATCH_RESET = 2'h0;
	localparam logic [1:0] PIN_ROUTE_RESET = 2'h0;

	// Last prescaler count for selects 1:1, 1:4, 1:16, 1:64
	localparam logic [3:0][5:0] PRE_LAST = {6'h3F, 6'h0F, 6'h03, 6'h00};
	localparam logic [1:0] SUB_LAST = 2'h3;

	typedef struct packed {
		logic [5:0] pre_cnt;
		logic [1:0] sub;
		logic [7:0] count;
		logic wrap;
	} pdu_tb_t;

	typedef struct packed {
		logic [7:0] duty_high;
		logic [1:0] duty_low;
		logic [9:0] duty_buf;
		logic enable;
		logic invert;
		logic level;
	} pdu_chan_t;

	typedef struct packed {
		pdu_chan_t [1:0] chan;
		logic [1:0] pin_dir;
		logic [1:0] pin_latch;
		logic [1:0] pin_route;
		logic [1:0] pin_oe;
		logic [1:0] pin_level;
		logic [1:0] pwm;
		logic [15:0] rdata;
	} pdu_state_t;

endpackage

// File: pdu_props.sv
// Port assertions for the pwm duty unit
`timescale 1ns/10ps
module pdu_props
(
	// Watched ports
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic sleep_in,
	input wire logic timer_run_in,
	input wire logic [1:0] timer_prescale_select_in,
	input wire logic [7:0] period_limit_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic [7:0] period_timer_count_out,
	input wire logic period_start_out,
	input wire logic [1:0] pwm_out,
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	chk_duty_read: assert property (
		$past(reg_read_in) && !$past(sleep_in) && $past(reg_addr_in) == 12'h38C
		|-> reg_rdata_out[5:0] == 6'h00) else $error("duty unused bits set");
	chk_reset_outs: assert property ($past(reset_in) |->
		pin_oe_out == 2'h0 && pwm_out == 2'h0 && !period_start_out) else $error("reset outputs");
	chk_sleep_hold: assert property ($past(sleep_in) && !$past(reset_in) |->
		$stable(period_timer_count_out) && $stable(pwm_out) && $stable(pin_oe_out)
		&& $stable(pin_out) && $stable(period_start_out))
		else $error("state moved in sleep");
	chk_start_zero: assert property (period_start_out |->
		period_timer_count_out == 8'h00) else $error("start with count not zero");
	chk_start_once: assert property (period_start_out && !sleep_in |=>
		!period_start_out) else $error("start pulse too long");
	chk_pin_dir: assert property (
		reg_write_in && !sleep_in && reg_addr_in == 12'h394
		|=> pin_oe_out == ~$past(reg_wdata_in[1:0])) else $error("pin enable wrong");
	chk_sub_step: assert property (
		period_start_out && period_limit_in != 8'h00 && timer_prescale_select_in == 2'h0
		&& timer_run_in && !sleep_in ##1 (timer_run_in && !sleep_in
		&& timer_prescale_select_in == 2'h0 && period_limit_in != 8'h00)[*4]
		|-> period_timer_count_out == 8'h01) else $error("time base step wrong");
	chk_timer_hold: assert property (!$past(timer_run_in) && !$past(reset_in) |->
		$stable(period_timer_count_out)) else $error("stopped timer moved");
endmodule
bind pdu_top pdu_props pdu_props_inst (.clk_in(clk_in), .reset_in(reset_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
	.reg_read_in(reg_read_in), .sleep_in(sleep_in), .timer_run_in(timer_run_in),
	.timer_prescale_select_in(timer_prescale_select_in), .period_limit_in(period_limit_in),
	.reg_rdata_out(reg_rdata_out), .period_timer_count_out(period_timer_count_out),
	.period_start_out(period_start_out), .pwm_out(pwm_out), .pin_out(pin_out),
	.pin_oe_out(pin_oe_out));

// File: pdu_time_base.sv
// Period timer with two-bit extension forming the ten-bit time base
`timescale 1ns/10ps
module pdu_time_base
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Timer control
	input wire logic sleep_in,
	input wire logic timer_run_in,
	input wire logic [1:0] timer_prescale_select_in,
	input wire logic [7:0] period_limit_in,
	// Time base
	output logic [7:0] count_out,
	output logic [1:0] sub_out,
	output logic wrap_out
);

	pdu_pkg::pdu_tb_t state;
	pdu_pkg::pdu_tb_t next_state;

	always_comb
	begin
		next_state = state;
		if (reset_in)
		begin
			next_state = '0;
		end
		else if (!sleep_in) // [RL8] [RL9]
		begin
			// A start pulse caught by sleep stands until wake, so no period is lost
			next_state.wrap = 1'b0;
			if (timer_run_in)
			begin
				// Derived from the system clock only, so the rate scales with it [RL10]
				if (state.pre_cnt >= pdu_pkg::PRE_LAST[timer_prescale_select_in]) // [RL4]
				begin
					next_state.pre_cnt = '0;
					if (state.sub == pdu_pkg::SUB_LAST) // [RL3]
					begin
						next_state.sub = '0;
						if (state.count == period_limit_in)
						begin
							next_state.count = '0;
							next_state.wrap = 1'b1;
						end
						else
						begin
							next_state.count = state.count + 8'h01;
						end
					end
					else
					begin
						next_state.sub = state.sub + 2'h1;
					end
				end
				else
				begin
					next_state.pre_cnt = state.pre_cnt + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		state <= next_state;
	end

	assign count_out = state.count;
	assign sub_out = state.sub;
	assign wrap_out = state.wrap;

endmodule

// File: pdu_top.sv
// Two-channel ten-bit pwm duty unit with register port and pin mux
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module pdu_top
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Register port
	input wire logic [11:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [15:0] reg_rdata_out,
	// Timer control and power state
	input wire logic sleep_in,
	input wire logic timer_run_in,
	input wire logic [1:0] timer_prescale_select_in,
	input wire logic [7:0] period_limit_in,
	// Timer status
	output logic [7:0] period_timer_count_out,
	output logic period_start_out,
	// Waveforms to on-chip peripherals
	output logic [1:0] pwm_out,
	// Pins
	output logic [1:0] pin_out,
	output logic [1:0] pin_oe_out
);

	pdu_pkg::pdu_state_t state;
	pdu_pkg::pdu_state_t next_state;

	logic [7:0] tb_count;
	logic [1:0] tb_sub;
	logic tb_wrap;
	logic [9:0] time_base;

	pdu_time_base u_time_base
	(
		.clk_in(clk_in),
		.reset_in(reset_in),
		.sleep_in(sleep_in),
		.timer_run_in(timer_run_in),
		.timer_prescale_select_in(timer_prescale_select_in),
		.period_limit_in(period_limit_in),
		.count_out(tb_count),
		.sub_out(tb_sub),
		.wrap_out(tb_wrap)
	);

	assign time_base = {tb_count, tb_sub}; // [RL3]

	// Whole resolution bits: floor(log2(4 * (limit + 1)))
	function automatic logic [3:0] resolution_bits(input logic [7:0] limit);
		logic [8:0] span;
		logic [3:0] bits;
		span = {1'b0, limit} + 9'h001;
		bits = 4'h2;
		for (int i = 1; i < 9; i++)
		begin
			if (span[i])
			begin
				bits = 4'(i + 2);
			end
		end
		return bits;
	endfunction

	// Ten-bit duty from the high byte and low bits [RL1]
	function automatic logic [9:0] duty_value(input pdu_pkg::pdu_chan_t ch);
		return {ch.duty_high, ch.duty_low};
	endfunction

	// Read view of a duty register
	function automatic logic [15:0] duty_read(input pdu_pkg::pdu_chan_t ch);
		logic [15:0] v;
		v = '0;
		v[pdu_pkg::DUTY_HIGH_LSB +: 8] = ch.duty_high;
		v[pdu_pkg::DUTY_LOW_LSB +: 2] = ch.duty_low;
		return v;
	endfunction

	// Read view of a control register
	function automatic logic [15:0] ctrl_read(input pdu_pkg::pdu_chan_t ch, input logic out);
		logic [15:0] v;
		v = '0;
		v[pdu_pkg::CTRL_EN_BIT] = ch.enable;
		v[pdu_pkg::CTRL_OUT_BIT] = out;
		v[pdu_pkg::CTRL_INVERT_BIT] = ch.invert;
		return v;
	endfunction

	always_comb
	begin
		next_state = state;
		// Read data stands for one cycle only
		next_state.rdata = '0;
		if (reset_in)
		begin
			for (int ch = 0; ch < pdu_pkg::CHANNELS; ch++)
			begin
				// Duty high and low fields keep their contents [RL12]
				next_state.chan[ch].duty_buf = '0;
				next_state.chan[ch].enable = 1'b0;
				next_state.chan[ch].invert = 1'b0;
				next_state.chan[ch].level = 1'b0;
			end
			next_state.pin_dir = pdu_pkg::PIN_DIR_RESET; // [RL11]
			next_state.pin_latch = pdu_pkg::PIN_LATCH_RESET;
			next_state.pin_route = pdu_pkg::PIN_ROUTE_RESET;
			next_state.pin_oe = '0;
			next_state.pin_level = '0;
			next_state.pwm = '0;
		end
		else if (!sleep_in) // [RL8]
		begin
			// Duty register writes land in the holding fields only [RL2]
			if (reg_write_in)
			begin
				for (int ch = 0; ch < pdu_pkg::CHANNELS; ch++)
				begin
					if (reg_addr_in == pdu_pkg::DUTY_OFS[ch])
					begin
						next_state.chan[ch].duty_high = reg_wdata_in[pdu_pkg::DUTY_HIGH_LSB +: 8];
						next_state.chan[ch].duty_low = reg_wdata_in[pdu_pkg::DUTY_LOW_LSB +: 2];
					end
					if (reg_addr_in == pdu_pkg::CTRL_OFS[ch])
					begin
						next_state.chan[ch].enable = reg_wdata_in[pdu_pkg::CTRL_EN_BIT];
						next_state.chan[ch].invert = reg_wdata_in[pdu_pkg::CTRL_INVERT_BIT];
					end
				end
				if (reg_addr_in == pdu_pkg::PIN_CTRL_OFS)
				begin
					next_state.pin_dir = reg_wdata_in[pdu_pkg::PIN_DIR_LSB +: 2];
					next_state.pin_latch = reg_wdata_in[pdu_pkg::PIN_LATCH_LSB +: 2];
					next_state.pin_route = reg_wdata_in[pdu_pkg::PIN_ROUTE_LSB +: 2];
				end
			end

			// Register reads, answered in the following cycle
			if (reg_read_in)
			begin
				for (int ch = 0; ch < pdu_pkg::CHANNELS; ch++)
				begin
					if (reg_addr_in == pdu_pkg::DUTY_OFS[ch])
					begin
						next_state.rdata = duty_read(state.chan[ch]);
					end
					if (reg_addr_in == pdu_pkg::CTRL_OFS[ch])
					begin
						next_state.rdata = ctrl_read(state.chan[ch], state.pwm[ch]);
					end
				end
				if (reg_addr_in == pdu_pkg::PIN_CTRL_OFS)
				begin
					next_state.rdata[pdu_pkg::PIN_DIR_LSB +: 2] = state.pin_dir;
					next_state.rdata[pdu_pkg::PIN_LATCH_LSB +: 2] = state.pin_latch;
					next_state.rdata[pdu_pkg::PIN_ROUTE_LSB +: 2] = state.pin_route;
				end
				if (reg_addr_in == pdu_pkg::TIMER_STAT_OFS)
				begin
					next_state.rdata[7:0] = tb_count;
					next_state.rdata[pdu_pkg::STAT_SUB_LSB +: 2] = tb_sub;
					next_state.rdata[pdu_pkg::STAT_RES_LSB +: 4] =
						resolution_bits(period_limit_in); // [RL6]
				end
			end

			// Waveform generation per channel
			for (int ch = 0; ch < pdu_pkg::CHANNELS; ch++)
			begin
				if (tb_wrap)
				begin
					// Buffers take the duty only at the period match [RL21]
					next_state.chan[ch].duty_buf = duty_value(state.chan[ch]);
					// Set at count clear if the channel is enabled and duty is not zero [RL19]
					next_state.chan[ch].level = state.chan[ch].enable &&
						(duty_value(state.chan[ch]) != 10'h000);
				end
				else if (state.chan[ch].enable && time_base == state.chan[ch].duty_buf)
				begin
					// A duty beyond the period never matches: full duty [RL20] [RL7] [RL5]
					next_state.chan[ch].level = 1'b0;
				end
				if (!next_state.chan[ch].enable)
				begin
					// Disabled: comparisons ignored, inactive level [RL23]
					next_state.chan[ch].level = 1'b0;
				end
				next_state.pwm[ch] = next_state.chan[ch].level ^
					next_state.chan[ch].invert; // [RL22]
			end

			// Pin mux onto the port latch path [RL18] [RL17]
			for (int p = 0; p < pdu_pkg::CHANNELS; p++)
			begin
				next_state.pin_level[p] = next_state.pin_route[p] ?
					next_state.pwm[p] : next_state.pin_latch[p];
				next_state.pin_oe[p] = !next_state.pin_dir[p];
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		state <= next_state;
	end

	assign reg_rdata_out = state.rdata;
	assign pwm_out = state.pwm;
	assign pin_out = state.pin_level;
	assign pin_oe_out = state.pin_oe;
	assign period_timer_count_out = tb_count;
	assign period_start_out = tb_wrap;

endmodule
